/* File: rtl/ripc_top.v */
// Reset, maskable-interrupt and bus-clock pin control.
// Assumes ref_clk is the external clock input; pins arrive asynchronous
// and are synchronised here. Software controls are plain ports.
`timescale 1ns/1ps
`default_nettype none
`include "ripc_regs.vh"

module ripc_top (
   input wire ref_clk,
   input wire rstn,
   input wire resetPinIn,
   output reg resetPinOut,
   output reg resetPinOe,
   output reg coreResetN,
   output reg [1:0] resetVector,
   output reg resetVectorValid,
   input wire watchdogFail,
   input wire clkMonFail,
   input wire [1:0] modePins,
   output reg [1:0] opMode,
   input wire busClockIn,
   output reg busClockOut,
   output reg busClockOe,
   output reg busTick,
   input wire clkOutWr,
   input wire clkOutOn,
   input wire stopMode,
   input wire stretchEn,
   input wire [1:0] stretchCycles,
   input wire slowAccess,
   input wire irqPin,
   input wire intCtlWr,
   input wire intCtlEdge,
   input wire condFlagsWr,
   input wire condFlagsMask,
   input wire irqAck,
   output reg irqEdgeMode,
   output reg irqMasked,
   output reg irqLevel,
   output reg irqRequest
);
   //***************************************************************
   // Reset pin: asynchronous entry, synchronous exit
   //***************************************************************
   reg rstMeta_q;
   reg rstSync_q;
   reg pinMeta_q;
   reg pinSync_q;
   wire seqPinOe;
   wire seqBusy;
   wire [1:0] seqVec;
   wire seqVecValid;

   // A dead clock must not stop the core entering reset
   always @(posedge ref_clk or negedge resetPinIn) begin
      if (!resetPinIn) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   always @(posedge ref_clk) begin
      pinMeta_q <= resetPinIn;
      pinSync_q <= pinMeta_q;
   end

   always @(posedge ref_clk or negedge resetPinIn) begin
      if (!resetPinIn) begin
         coreResetN <= 1'b0;
      end else begin
         coreResetN <= rstSync_q & rstn & ~seqBusy;
      end
   end

   ripc_rst_seq uSeq (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .busTick(busTick),
      .watchdogFail(watchdogFail),
      .clkMonFail(clkMonFail),
      .pinLevel(pinSync_q),
      .pinOe(seqPinOe),
      .seqBusy(seqBusy),
      .vecSel(seqVec),
      .vecValid(seqVecValid)
   );

   always @(posedge ref_clk) begin
      if (!rstn) begin
         resetPinOut <= 1'b0;
         resetPinOe <= 1'b0;
         resetVector <= `RIPC_VEC_RESET;
         resetVectorValid <= 1'b0;
      end else begin
         // Open drain: the pin level is only ever driven low
         resetPinOut <= 1'b0;
         resetPinOe <= seqPinOe;
         if (seqVecValid) begin
            resetVector <= seqVec;
            resetVectorValid <= 1'b1;
         end else if (!rstSync_q && !seqBusy) begin
            // Pin pulled low from outside with no internal cause
            resetVector <= `RIPC_VEC_RESET;
            resetVectorValid <= 1'b1;
         end
      end
   end

   //***************************************************************
   // Mode straps, caught while the core is held in reset
   //***************************************************************
   reg [1:0] modeMeta_q;
   reg [1:0] modeSync_q;

   always @(posedge ref_clk) begin
      modeMeta_q <= modePins;
      modeSync_q <= modeMeta_q;
   end

   always @(posedge ref_clk) begin
      if (!rstn || !coreResetN) begin
         opMode <= modeSync_q;
      end
   end

   //***************************************************************
   // Bus clock: half the reference rate, stretchable, stoppable; in peripheral mode ticks follow the external clock instead
   //***************************************************************
   reg extMeta_q;
   reg extSync_q;
   reg extPrev_q;
   reg [1:0] stretch_q;
   wire peripheral = (opMode == `RIPC_MODE_SPEC_PER);
   wire extFall = extPrev_q & ~extSync_q;
   wire holdHigh = stretchEn & slowAccess & (stretch_q != 2'h0);

   always @(posedge ref_clk) begin
      extMeta_q <= busClockIn;
      extSync_q <= extMeta_q;
      extPrev_q <= extSync_q;
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         busClockOut <= 1'b0;
         busTick <= 1'b0;
         stretch_q <= 2'h0;
      end else if (peripheral) begin
         // Timing follows the bus clock supplied from outside
         busClockOut <= 1'b0;
         busTick <= extFall;
         stretch_q <= 2'h0;
      end else if (stopMode) begin
         busClockOut <= 1'b0;
         busTick <= 1'b0;
         stretch_q <= 2'h0;
      end else if (!busClockOut) begin
         busClockOut <= 1'b1;
         busTick <= 1'b0;
         stretch_q <= stretchCycles;
      end else if (holdHigh) begin
         // Extra high time per stretch count, at the reference rate
         stretch_q <= stretch_q - 2'h1;
         busTick <= 1'b0;
      end else begin
         busClockOut <= 1'b0;
         busTick <= 1'b1;
      end
   end

   // Output enable chosen per mode while in reset, software after except in peripheral mode, where it stays off
   always @(posedge ref_clk) begin
      if (!rstn || !coreResetN) begin
         case (modeSync_q)
            `RIPC_MODE_NORM_SC: busClockOe <= 1'b0;
            `RIPC_MODE_SPEC_SC: busClockOe <= 1'b1;
            `RIPC_MODE_SPEC_PER: busClockOe <= 1'b0;
            default: busClockOe <= 1'b1;
         endcase
      end else if (peripheral) begin
         busClockOe <= 1'b0;
      end else if (clkOutWr) begin
         busClockOe <= clkOutOn;
      end
   end

   //***************************************************************
   // Maskable interrupt pin
   //***************************************************************
   reg irqMeta_q;
   reg irqSync_q;
   reg irqPrev_q;
   reg pending_q;
   wire irqFall = irqPrev_q & ~irqSync_q;

   always @(posedge ref_clk) begin
      irqMeta_q <= irqPin;
      irqSync_q <= irqMeta_q;
      irqPrev_q <= irqSync_q;
   end

   always @(posedge ref_clk) begin
      if (!rstn || !coreResetN) begin
         irqEdgeMode <= 1'b0;
         irqMasked <= 1'b1;
         pending_q <= 1'b0;
         irqLevel <= 1'b1;
         irqRequest <= 1'b0;
      end else begin
         irqLevel <= irqSync_q;
         if (intCtlWr) begin
            irqEdgeMode <= intCtlEdge;
         end
         if (condFlagsWr) begin
            irqMasked <= condFlagsMask;
         end
         // A fresh edge in the acknowledge cycle stays pending
         if (irqEdgeMode && irqFall) begin
            pending_q <= 1'b1;
         end else if (irqAck || !irqEdgeMode) begin
            pending_q <= 1'b0;
         end
         irqRequest <= ~irqMasked &
            (irqEdgeMode ? pending_q : ~irqSync_q);
      end
   end
endmodule // ripc_top

`default_nettype wire

/* File: rtl/ripc_regs.vh */
// Constants for the reset, interrupt and bus-clock pin control block.
// Assumes one 40 MHz clock (ref_clk), the external clock input itself.
`ifndef RIPC_REGS_VH
`define RIPC_REGS_VH

// Operating modes, as strapped on the mode pins
`define RIPC_MODE_NORM_SC 2'h0
`define RIPC_MODE_SPEC_SC 2'h1
`define RIPC_MODE_SPEC_PER 2'h2
`define RIPC_MODE_EXPANDED 2'h3

// Reset vector selection
`define RIPC_VEC_RESET 2'h0
`define RIPC_VEC_WATCHDOG 2'h1
`define RIPC_VEC_CLKMON 2'h2

// Timing in bus-clock cycles
`define RIPC_DRIVE_CYC 5'h10
`define RIPC_SAMPLE_CYC 5'h08
`define RIPC_EXT_HOLD_CYC 6'h20

// Reset sequencer states
`define RIPC_ST_IDLE 2'h0
`define RIPC_ST_DRIVE 2'h1
`define RIPC_ST_WAIT 2'h2
`define RIPC_ST_DONE 2'h3

`endif

/* File: rtl/ripc_rst_seq.v */
// Internal-reset sequencer: drives the reset pin low, releases it,
// samples it and picks the reset vector. Counts bus-clock ticks.
`timescale 1ns/1ps
`default_nettype none
`include "ripc_regs.vh"

module ripc_rst_seq (
   input wire ref_clk,
   input wire rstn,
   input wire busTick,
   input wire watchdogFail,
   input wire clkMonFail,
   input wire pinLevel,
   output reg pinOe,
   output reg seqBusy,
   output reg [1:0] vecSel,
   output reg vecValid
);
   localparam [1:0] ST_IDLE = `RIPC_ST_IDLE;
   localparam [1:0] ST_DRIVE = `RIPC_ST_DRIVE;
   localparam [1:0] ST_WAIT = `RIPC_ST_WAIT;
   localparam [1:0] ST_DONE = `RIPC_ST_DONE;

   reg [1:0] state_q;
   reg [4:0] cnt_q;
   reg cause_q;

   always @(posedge ref_clk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         cnt_q <= 5'h00;
         cause_q <= 1'b0;
         pinOe <= 1'b0;
         seqBusy <= 1'b0;
         vecSel <= `RIPC_VEC_RESET;
         vecValid <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               vecValid <= 1'b0;
               if (watchdogFail || clkMonFail) begin
                  // Watchdog wins when both fail in the same cycle
                  cause_q <= ~watchdogFail;
                  state_q <= ST_DRIVE;
                  pinOe <= 1'b1;
                  seqBusy <= 1'b1;
                  cnt_q <= 5'h00;
               end
            end
            ST_DRIVE: begin
               if (busTick) begin
                  if (cnt_q == `RIPC_DRIVE_CYC - 5'h01) begin
                     pinOe <= 1'b0;
                     cnt_q <= 5'h00;
                     state_q <= ST_WAIT;
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
            end
            ST_WAIT: begin
               if (busTick) begin
                  if (cnt_q == `RIPC_SAMPLE_CYC - 5'h01) begin
                     state_q <= ST_DONE;
                     if (pinLevel) begin
                        vecSel <= cause_q ? `RIPC_VEC_CLKMON
                                          : `RIPC_VEC_WATCHDOG;
                     end else begin
                        vecSel <= `RIPC_VEC_RESET;
                     end
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
            end
            ST_DONE: begin
               vecValid <= 1'b1;
               seqBusy <= 1'b0;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // ripc_rst_seq

`default_nettype wire

/* File: dv/ripc_props.sv */
// Assertions on the reset, interrupt and bus-clock pin control ports.
// Bound to ripc_top from tb_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ripc_props (
   input wire ref_clk,
   input wire rstn,
   input wire resetPinIn,
   input wire resetPinOut,
   input wire resetPinOe,
   input wire coreResetN,
   input wire resetVectorValid,
   input wire [1:0] opMode,
   input wire busClockOut,
   input wire busClockOe,
   input wire busTick,
   input wire stopMode,
   input wire stretchEn,
   input wire intCtlWr,
   input wire condFlagsWr,
   input wire irqAck,
   input wire irqEdgeMode,
   input wire irqMasked,
   input wire irqLevel,
   input wire irqRequest
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [7:0] oeCnt_q;
   // Counts how long the pin has been pulled low by the device
   always @(posedge ref_clk) oeCnt_q <= resetPinOe ? oeCnt_q + 8'h01 : 8'h00;
   a_drain_low: assert property (resetPinOe |-> !resetPinOut)
      else $error("reset pin driven high");
   a_drive_len: assert property ($fell(resetPinOe) |->
      oeCnt_q inside {[8'h1E:8'h22]}) else $error("drive length wrong");
   a_sample_gap: assert property ($fell(resetPinOe) |->
      ##[12:24] resetVectorValid) else $error("no vector after release");
   a_core_async: assert property (!resetPinIn |-> !coreResetN)
      else $error("core not in reset with pin low");
   a_core_sync: assert property ($rose(coreResetN) |->
      resetPinIn && $past(resetPinIn)) else $error("early reset exit");
   a_stop_halt: assert property (stopMode[*3] |->
      !busClockOut && !busTick) else $error("clock runs in stop");
   a_periph_input: assert property (opMode == 2'h2 |-> !busClockOe)
      else $error("clock pin driven in peripheral mode");
   a_clk_toggle: assert property (!stopMode && !$past(stopMode) &&
      !stretchEn && opMode != 2'h2 && $past(rstn) |->
      busClockOut != $past(busClockOut)) else $error("bus clock stuck");
   a_tick_fall: assert property (busTick && opMode != 2'h2 |->
      !busClockOut && $past(busClockOut)) else $error("tick off fall");
   a_irq_reset: assert property (disable iff (1'h0)
      !rstn |=> irqMasked && !irqEdgeMode && !irqRequest)
      else $error("interrupt reset state wrong");
   a_mask_block: assert property (irqMasked && $past(irqMasked)
      |-> !irqRequest) else $error("masked request seen");
   a_level_trig: assert property ((!irqEdgeMode && !irqMasked
      && !irqLevel)[*3] |-> irqRequest) else $error("level request lost");
   // The request seen now was built one edge back, so the clears are
   // looked at one edge back too; a pin reset may cut the request short
   a_edge_hold: assert property (irqEdgeMode && $past(irqEdgeMode)
      && irqRequest && coreResetN && !$past(irqAck)
      && !$past(condFlagsWr) |=> irqRequest || !coreResetN)
      else $error("pending edge dropped");
endmodule // ripc_props
`default_nettype wire

/* File: dv/ripc_ext_model.sv */
// External reset circuit and interrupt source on the far side.
// Both lines are pulled up; parties only ever pull them low.
`timescale 1ns/1ps
`default_nettype none
module ripc_ext_model (
   input wire ref_clk,
   input wire devOe,
   input wire holdReq,
   input wire irqLow,
   output logic resetPin,
   output logic irqPin
);
   logic [6:0] holdCnt_q = 7'h00;
   // A request holds the pin 64 reference cycles, just the 32 bus-cycle minimum
   always @(posedge ref_clk) holdCnt_q <= holdReq ? 7'h40 :
      (holdCnt_q != 7'h00 ? holdCnt_q - 7'h01 : 7'h00);
   assign resetPin = !(devOe || holdCnt_q != 7'h00);
   assign irqPin = !irqLow;
endmodule // ripc_ext_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for ripc_top with the external pin model.
// Inputs move 2 ns after each rising edge of the 25 ns clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'h0, rstn = 1'h0, watchdogFail = 1'h0, clkMonFail = 1'h0;
   logic busClockIn = 1'h0, clkOutWr = 1'h0, clkOutOn = 1'h0, stopMode = 1'h0;
   logic stretchEn = 1'h0, slowAccess = 1'h0, intCtlWr = 1'h0, irqAck = 1'h0;
   logic intCtlEdge = 1'h0, condFlagsWr = 1'h0, condFlagsMask = 1'h1;
   logic holdReq = 1'h0, irqLow = 1'h0;
   logic [1:0] modePins = 2'h0, stretchCycles = 2'h2;
   wire resetPinIn, resetPinOut, resetPinOe, coreResetN, resetVectorValid;
   wire busClockOut, busClockOe, busTick, irqPin, irqEdgeMode, irqMasked;
   wire irqLevel, irqRequest;
   wire [1:0] resetVector, opMode;
   int error_cnt = 0, check_count = 0, c;
   ripc_top i_ripc_top (.ref_clk, .rstn, .resetPinIn, .resetPinOut,
      .resetPinOe, .coreResetN, .resetVector, .resetVectorValid,
      .watchdogFail, .clkMonFail, .modePins, .opMode, .busClockIn,
      .busClockOut, .busClockOe, .busTick, .clkOutWr, .clkOutOn, .stopMode,
      .stretchEn, .stretchCycles, .slowAccess, .irqPin, .intCtlWr,
      .intCtlEdge, .condFlagsWr, .condFlagsMask, .irqAck, .irqEdgeMode,
      .irqMasked, .irqLevel, .irqRequest);
   ripc_ext_model i_ripc_ext_model (.ref_clk, .devOe(resetPinOe), .holdReq,
      .irqLow, .resetPin(resetPinIn), .irqPin);
   initial forever #12.5 ref_clk = ~ref_clk;
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task step; @(posedge ref_clk); #2; endtask
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
      check_count++;
      if (seen !== ex) begin
         error_cnt++;
         $display("MISMATCH %s exp %0h seen %0h", nm, ex, seen);
      end
   endtask
   task rst(input logic [1:0] m);
      rstn = 1'h0; modePins = m; repeat (5) step; rstn = 1'h1; repeat (4) step;
   endtask
   task ticks(input int n); c = 0; repeat (n) begin step; c += busTick; end
   endtask
   task wrOe(input logic v); clkOutWr = 1'h1; clkOutOn = v; step;
      clkOutWr = 1'h0; step; endtask
   task t_modes;
      rst(2'h0); chk("oe0", busClockOe, 0);
      chk("mask", irqMasked, 1); chk("edge", irqEdgeMode, 0);
      wrOe(1'h1); chk("oe0on", busClockOe, 1);
      rst(2'h1); chk("oe1", busClockOe, 1);
      wrOe(1'h0); chk("oe1off", busClockOe, 0);
      rst(2'h3); chk("oe3", busClockOe, 1);
      rst(2'h2); chk("mode", opMode, 2); c = 0;
      repeat (16) begin busClockIn = ~busClockIn; step; c += busTick; step;
         c += busTick; end
      // The last falling edge shows up three edges late, after the loop
      repeat (4) begin step; c += busTick; end
      chk("oe2", busClockOe, 0); chk("exttick", c, 8);
   endtask
   task t_clock;
      rst(2'h0); ticks(20); chk("ticks", c, 10);
      stopMode = 1'h1; step; step; ticks(20); chk("stop", c, 0);
      chk("stopclk", busClockOut, 0);
      stopMode = 1'h0; stretchEn = 1'h1; slowAccess = 1'h1; ticks(24);
      chk("stretch", c inside {[5:7]}, 1);
      // Let any stretched phase finish before the enable drops
      slowAccess = 1'h0; repeat (8) step; stretchEn = 1'h0;
   endtask
   task t_intrst(input logic wd, cm, hd, input logic [1:0] ex);
      logic sawOe, sawCore, sawHigh;
      int oeN;
      rst(2'h0); sawOe = 0; sawCore = 0; sawHigh = 0; oeN = 0;
      watchdogFail = wd; clkMonFail = cm; holdReq = hd; step;
      watchdogFail = 1'h0; clkMonFail = 1'h0; holdReq = 1'h0;
      for (int i = 0; i < 200 && resetVectorValid !== 1'h1; i++) begin
         step; sawOe |= resetPinOe; sawCore |= !coreResetN;
         sawHigh |= resetPinOe & resetPinOut; oeN += resetPinOe; end
      // A hang must not pass on the reset value of the vector
      chk("valid", resetVectorValid, 1);
      chk("vector", resetVector, ex);
      chk("pulled", sawOe, 1); chk("core", sawCore, 1);
      chk("drain", sawHigh, 0);
      // Sixteen bus cycles are 31 or 32 reference cycles, by phase
      chk("drivelen", oeN inside {[31:32]}, 1);
   endtask
   task t_irq;
      rst(2'h0); irqLow = 1'h1; repeat (6) step;
      chk("masked", irqRequest, 0); chk("lvl0", irqLevel, 0);
      condFlagsWr = 1'h1; condFlagsMask = 1'h0; step; condFlagsWr = 1'h0;
      repeat (6) step; chk("lvlreq", irqRequest, 1);
      irqLow = 1'h0; repeat (6) step; chk("lvlgone", irqRequest, 0);
      chk("lvl1", irqLevel, 1);
      intCtlWr = 1'h1; intCtlEdge = 1'h1; step; intCtlWr = 1'h0;
      chk("edgemode", irqEdgeMode, 1);
      irqLow = 1'h1; step; step; irqLow = 1'h0; repeat (6) step;
      chk("pend", irqRequest, 1);
      irqAck = 1'h1; step; irqAck = 1'h0; step; chk("ack", irqRequest, 0);
   endtask
   task summarize;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++; summarize;
   end
   initial begin
      t_modes; t_clock; t_irq;
      t_intrst(1'h1, 1'h0, 1'h0, 2'h1); t_intrst(1'h0, 1'h1, 1'h0, 2'h2);
      t_intrst(1'h1, 1'h1, 1'h0, 2'h1); t_intrst(1'h1, 1'h0, 1'h1, 2'h0);
      summarize;
   end
endmodule // tb_top
bind ripc_top ripc_props i_ripc_props (.ref_clk, .rstn, .resetPinIn,
   .resetPinOut, .resetPinOe, .coreResetN, .resetVectorValid, .opMode,
   .busClockOut, .busClockOe, .busTick, .stopMode, .stretchEn, .intCtlWr,
   .condFlagsWr, .irqAck, .irqEdgeMode, .irqMasked, .irqLevel, .irqRequest);
`default_nettype wire
